// [src/acf_map.svh]
// Constants for the converter serial control frame
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH

`define ACF_CFG_W 12
`define ACF_CFG_RST 12'h000
`define ACF_WRITE_BIT 11
`define ACF_CFG_EDGES 5'h0C
`define ACF_FRAME_EDGES 5'h10
`define ACF_LEAD_ZEROS 2
`define ACF_FIFO_DEPTH 16

`endif

// [src/acf_pkg.sv]
// Types for the converter serial control frame
package acf_pkg;

  typedef enum logic [1:0] {
    ACF_ST_IDLE  = 2'b00,
    ACF_ST_LOAD  = 2'b01,
    ACF_ST_SHIFT = 2'b10
  } acf_state_t;

endpackage

// [src/acf_fifo.sv]
// Result FIFO between the conversion core and the serial frame
`timescale 1ns/1ps

module acf_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic ready_reg;
  logic [WIDTH-1:0] data_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = in_valid && !full_reg;
  assign do_rd = out_ready && (count_reg != '0);
  // Ready leaves a flop so the port carries no gate
  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = data_reg;

  always_comb begin
    count_next = count_reg;
    if (do_wr && !do_rd) begin
      count_next = count_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Read data leaves from a register, one cycle after the pop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_reg <= '0;
    end else if (do_rd) begin
      data_reg <= mem[rd_ptr_reg];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      full_reg <= (count_next == (AW + 1)'(DEPTH));
      ready_reg <= (count_next != (AW + 1)'(DEPTH));
    end
  end

endmodule // acf_fifo

// [src/acf_frame.sv]
// Serial frame logic: configuration word in, conversion result out
//
// Functional notes
// - Twelve-bit configuration register, write only, never read back.
// - Each configuration bit is sampled on a serial clock falling edge.
// - Configuration shifts in while the result shifts out, same edges.
// - A received configuration applies to the next conversion, not this one.
// - Only the first twelve falling edges after select falls are captured.
// - Configuration arrives most significant bit first.
// - Top bit one loads the word; zero leaves the register unchanged.
// - Output: two zeros, two channel bits, twelve result bits MSB first.
// - The first output bit is driven when select falls; each later bit on a serial clock falling edge.
// - Select falling starts a conversion; low select frames the transfer.
`timescale 1ns/1ps
`include "acf_map.svh"

module acf_frame #(
  parameter int DATA_W = 12,
  parameter int CHAN_W = 2,
  parameter int DEPTH = `ACF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Results from the conversion core
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [DATA_W-1:0] res_data,
  input wire logic [CHAN_W-1:0] res_chan,
  // Conversion core control
  output logic conv_start,
  output logic [`ACF_CFG_W-1:0] cfg_word,
  output logic cfg_update
);

  localparam int WORD_W = `ACF_LEAD_ZEROS + CHAN_W + DATA_W;

  // Pin synchronisers
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic din_meta;
  logic din_sync;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Idle level high, so no false edge follows reset
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      sclk_meta <= sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      din_meta <= din;
      din_sync <= din_meta;
    end
  end

  // Data and clock share the same delay, so they stay aligned
  assign sclk_fall = sclk_prev && !sclk_sync;
  assign cs_fall = cs_prev && !cs_sync;
  assign cs_rise = !cs_prev && cs_sync;

  // Result FIFO
  logic fifo_valid;
  logic fifo_pop;
  logic [CHAN_W+DATA_W-1:0] fifo_data;

  acf_fifo #(
    .WIDTH(CHAN_W + DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data({res_chan, res_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Frame sequencing
  acf_pkg::acf_state_t state_reg;
  logic [4:0] edge_cnt_reg;
  logic popped_reg;
  logic [CHAN_W+DATA_W-1:0] last_word_reg;

  assign fifo_pop = cs_fall && fifo_valid;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= acf_pkg::ACF_ST_IDLE;
      edge_cnt_reg <= 5'h00;
      popped_reg <= 1'b0;
    end else if (cs_rise) begin
      state_reg <= acf_pkg::ACF_ST_IDLE;
    end else begin
      unique case (state_reg)
        acf_pkg::ACF_ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= acf_pkg::ACF_ST_LOAD;
            popped_reg <= fifo_pop;
            edge_cnt_reg <= 5'h00;
          end
        end
        acf_pkg::ACF_ST_LOAD: begin
          state_reg <= acf_pkg::ACF_ST_SHIFT;
        end
        acf_pkg::ACF_ST_SHIFT: begin
          // Edges past the sixteenth are counted no further
          if (sclk_fall && edge_cnt_reg != `ACF_FRAME_EDGES) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= acf_pkg::ACF_ST_IDLE;
        end
      endcase
    end
  end

  // Conversion start pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= cs_fall && state_reg == acf_pkg::ACF_ST_IDLE;
    end
  end

  // Output shift path
  logic [WORD_W-1:0] tx_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_word_reg <= '0;
    end else if (state_reg == acf_pkg::ACF_ST_LOAD && popped_reg) begin
      last_word_reg <= fifo_data;
    end
  end

  // An empty FIFO repeats the last result rather than inventing one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_reg <= '0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else if (cs_rise) begin
      dout_oe <= 1'b0;
      dout <= 1'b0;
    end else if (state_reg == acf_pkg::ACF_ST_IDLE && cs_fall) begin
      dout_oe <= 1'b1;
      dout <= 1'b0;
    end else if (state_reg == acf_pkg::ACF_ST_LOAD) begin
      tx_reg <= {{`ACF_LEAD_ZEROS{1'b0}}, popped_reg ? fifo_data : last_word_reg};
    end else if (state_reg == acf_pkg::ACF_ST_SHIFT && sclk_fall) begin
      tx_reg <= {tx_reg[WORD_W-2:0], 1'b0};
      dout <= tx_reg[WORD_W-2];
    end
  end

  // Configuration capture
  logic [`ACF_CFG_W-2:0] rx_reg;
  logic [`ACF_CFG_W-1:0] rx_word;
  logic [`ACF_CFG_W-1:0] pend_reg;
  logic pend_valid_reg;

  assign rx_word = {rx_reg, din_sync};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_reg <= '0;
    end else if (state_reg == acf_pkg::ACF_ST_SHIFT && sclk_fall
                 && edge_cnt_reg < `ACF_CFG_EDGES) begin
      rx_reg <= rx_word[`ACF_CFG_W-2:0];
    end
  end

  // Word held until frame end so the running conversion keeps its setup
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_reg <= `ACF_CFG_RST;
      pend_valid_reg <= 1'b0;
    end else if (state_reg == acf_pkg::ACF_ST_IDLE && cs_fall) begin
      pend_valid_reg <= 1'b0;
    end else if (state_reg == acf_pkg::ACF_ST_SHIFT && sclk_fall
                 && edge_cnt_reg == `ACF_CFG_EDGES - 5'h01) begin
      if (rx_word[`ACF_WRITE_BIT]) begin
        pend_reg <= rx_word;
        pend_valid_reg <= 1'b1;
      end
    end
  end

  // Write-only: no path leads this register back to the pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_word <= `ACF_CFG_RST;
      cfg_update <= 1'b0;
    end else begin
      cfg_update <= 1'b0;
      if (cs_rise && pend_valid_reg) begin
        cfg_word <= pend_reg;
        cfg_update <= 1'b1;
      end
    end
  end

endmodule // acf_frame

// [verif/acf_checker.sv]
// Port assertions for the serial frame block
`timescale 1ns/1ps
module acf_checker #(
  parameter int DATA_W = 12,
  parameter int CHAN_W = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  // Results
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic [DATA_W-1:0] res_data,
  input wire logic [CHAN_W-1:0] res_chan,
  // Core control
  input wire logic conv_start,
  input wire logic [11:0] cfg_word,
  input wire logic cfg_update
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Serial clock history, so output changes can be tied to a falling edge
  logic [4:0] sh_reg;
  always_ff @(posedge clk_sys) begin
    sh_reg <= {sh_reg[3:0], sclk};
  end
  a_start_oe: assert property ($fell(cs_n) |-> ##[2:3] conv_start && dout_oe)
    else $error("no start after select fall");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_upd_pulse: assert property (cfg_update |=> !cfg_update)
    else $error("update pulse too long");
  a_upd_change: assert property ($changed(cfg_word) |-> cfg_update)
    else $error("config changed without update pulse");
  a_cfg_write: assert property ($changed(cfg_word) |-> cfg_word[11])
    else $error("config loaded without write bit");
  a_cfg_late: assert property ($changed(cfg_word) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("config changed inside frame");
  a_oe_off: assert property (cs_n [*5] |-> !dout_oe)
    else $error("output driven outside frame");
  a_dout_edge: assert property ($changed(dout) && dout_oe && $past(dout_oe) && !$past(cs_n, 2)
    |-> sh_reg[4] && !sh_reg[0])
    else $error("output bit changed without clock fall");
  a_first_zero: assert property ($rose(dout_oe) |-> !dout && conv_start)
    else $error("first output bit not zero");
  cover property (conv_start);
  cover property (cfg_update);
  cover property (!res_ready);
endmodule // acf_checker

// [verif/acf_host.sv]
// Host serial port model: select, serial clock and config data
`timescale 1ns/1ps
module acf_host (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Clock idles high between frames; data is scrambled when unused
  task automatic frame(input logic [11:0] cfg, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    din = cfg[11];
    // Odd offset keeps every serial clock edge clear of the system clock edges; select falls on a system clock falling edge
    #61.25 rx[15] = dout;
    for (int k = 1; k <= n; k++) begin
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
      if (k < 16) rx[15-k] = dout;
      din = (k < 12) ? cfg[11-k] : ~din;
    end
    #62.5 cs_n = 1'b1;
    din = ~din;
    #62.5;
  endtask
endmodule // acf_host

// [verif/tb_top.sv]
// Testbench for the serial frame block
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [11:0] cfg; logic [11:0] data; logic [1:0] chan;
    logic [11:0] exp;} acf_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic res_valid = 1'b0;
  logic [11:0] res_data = 12'h000;
  logic [1:0] res_chan = 2'h0;
  logic sclk, cs_n, din, dout, dout_oe, res_ready, conv_start, cfg_update;
  logic [11:0] cfg_word;
  logic dout_line;
  logic [15:0] rx;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  acf_row_t rows [4] = '{'{12'h8A5, 12'hABC, 2'h0, 12'h8A5},
    '{12'h123, 12'h001, 2'h1, 12'h8A5},
    '{12'hFFF, 12'hFFF, 2'h2, 12'hFFF},
    '{12'h800, 12'h800, 2'h3, 12'h800}};
  always #5 clk_sys = ~clk_sys;
  acf_frame dut (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .res_chan(res_chan), .conv_start(conv_start),
    .cfg_word(cfg_word), .cfg_update(cfg_update));
  // Released pin shows the inverse, so a late enable is caught
  assign dout_line = dout_oe ? dout : ~dout;
  acf_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic push(input logic [11:0] d, input logic [1:0] c);
    @(negedge clk_sys);
    res_valid = 1'b1;
    res_data = d;
    res_chan = c;
    @(negedge clk_sys);
    res_valid = 1'b0;
  endtask
  task automatic run(input logic [11:0] cfg, input int n, input logic [11:0] exp);
    host.frame(cfg, n, rx);
    repeat (4) @(negedge clk_sys);
    chk("cfg_word", cfg_word, exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    chk("cfg_reset", cfg_word, 12'h000);
    chk("ready_reset", res_ready, 1'b1);
    repeat (4) @(negedge clk_sys);
    $display("test reset done");
    foreach (rows[i]) begin
      push(rows[i].data, rows[i].chan);
      run(rows[i].cfg, 16, rows[i].exp);
      chk("dout_word", rx, {2'b00, rows[i].chan, rows[i].data});
      $display("test row %0d done", i);
    end
    // Too few edges must leave the word alone; exactly twelve must load it
    // Empty FIFO: the last result goes out again, seen only as far as clocked
    run(12'hFFF, 8, 12'h800);
    chk("dout_repeat", rx, 16'h3800);
    run(12'h9C3, 12, 12'h9C3);
    chk("dout_repeat", rx, 16'h3800);
    $display("test edge count done");
    for (int i = 0; i < 16; i++) push(12'(i * 257), 2'(i));
    @(negedge clk_sys);
    chk("fifo_full", res_ready, 1'b0);
    for (int i = 0; i < 16; i++) begin
      run(12'h7FF, 16, 12'h9C3);
      chk("fifo_order", rx, {2'b00, 2'(i), 12'(i * 257)});
    end
    $display("test fifo done");
    results();
  end
endmodule // tb_top
bind acf_frame acf_checker #(.DATA_W(DATA_W), .CHAN_W(CHAN_W)) chk_i (.*);
